// ===== vic_pkg.sv
// Package of register offsets, field layouts and constants for the vectored controller.
package vic_pkg;
	localparam int NUM_SRC = 32;
	localparam logic [31:0] BASE_ADDR = 32'hfffff000;
	localparam logic [31:0] WINDOW_MASK = 32'hfffff000;
	localparam logic [11:0] OFF_MODE_FIRST = 12'h000;
	localparam logic [11:0] OFF_MODE_LAST = 12'h07c;
	localparam logic [11:0] OFF_HANDLER_FIRST = 12'h080;
	localparam logic [11:0] OFF_HANDLER_LAST = 12'h0fc;
	localparam logic [11:0] OFF_NORMAL_VECTOR = 12'h100;
	localparam logic [11:0] OFF_FAST_VECTOR = 12'h104;
	localparam logic [11:0] OFF_CURRENT_ID = 12'h108;
	localparam logic [11:0] OFF_PENDING = 12'h10c;
	localparam logic [11:0] OFF_ENABLED = 12'h110;
	localparam logic [11:0] OFF_CORE_LINES = 12'h114;
	localparam logic [11:0] OFF_ENABLE_CMD = 12'h120;
	localparam logic [11:0] OFF_DISABLE_CMD = 12'h124;
	localparam logic [11:0] OFF_CLEAR_CMD = 12'h128;
	localparam logic [11:0] OFF_SET_CMD = 12'h12c;
	localparam logic [11:0] OFF_END_SERVICE = 12'h130;
	localparam logic [11:0] OFF_SPURIOUS = 12'h134;
	localparam logic [11:0] OFF_DEBUG = 12'h138;
	localparam logic [11:0] OFF_FAST_EN = 12'h140;
	localparam logic [11:0] OFF_FAST_DIS = 12'h144;
	localparam logic [11:0] OFF_FAST_STATE = 12'h148;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h150;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h154;
	localparam int PRIO_LSB = 0;
	localparam int PRIO_W = 3;
	localparam int SENSE_LSB = 5;
	localparam int SENSE_W = 2;
	localparam int MODE_W = 7;
	localparam logic [6:0] MODE_WMASK = 7'h67;
	localparam int DBG_PROTECT_BIT = 0;
	localparam int DBG_GMASK_BIT = 1;
	localparam logic [1:0] DBG_WMASK = 2'h3;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [31:0] EXTERNAL_SRC_DEFAULT = 32'hc0000000;
	localparam int STACK_DEPTH = 8;
	localparam int EVT_SPURIOUS = 0;
	localparam int EVT_NORMAL = 1;
	localparam int EVT_FAST = 2;
	localparam int EVT_W = 3;
	typedef enum logic [1:0] {
		VIC_IDLE = 2'b00,
		VIC_SERVE = 2'b01,
		VIC_PROTECT_HOLD = 2'b11
	} vic_state_e;
endpackage : vic_pkg

// ===== vic_source_detect.sv
// Trigger sense decoding and pending flag keeping for all sources.
`timescale 1ns/1ps
module vic_source_detect (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] src_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] external_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] edge_mode_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] active_high_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] set_i,
	input wire logic [vic_pkg::NUM_SRC-1:0] clear_i,
	output logic [vic_pkg::NUM_SRC-1:0] pending_o
);
	import vic_pkg::*;

	typedef struct packed {
		logic [NUM_SRC-1:0] level;
		logic [NUM_SRC-1:0] edge_flag;
		logic primed;
	} vic_det_s;

	vic_det_s st_q;
	vic_det_s st_d;
	logic [NUM_SRC-1:0] active;

	////////////////////////////////////////////////////////////////////////////////
	// Active level after polarity; edges need one prior sample, so none fire at reset.
	always_comb begin
		active = ~(src_i ^ active_high_i);
		st_d = st_q;
		st_d.level = active;
		st_d.primed = 1'b1;
		if (sys_rst_i) begin
			st_d.level = active;
			st_d.edge_flag = '0;
			st_d.primed = 1'b0;
		end else begin
			// Set beats clear so a coincident edge is kept.
			st_d.edge_flag = (st_q.edge_flag & ~clear_i) | set_i |
				({NUM_SRC{st_q.primed}} & active & ~st_q.level & edge_mode_i);
		end
	end

	// External level sources show their input live right out of reset; internal ones only one cycle later.
	always_comb begin
		pending_o = (edge_mode_i & st_q.edge_flag) |
			(~edge_mode_i & ((active & external_i & ~{NUM_SRC{sys_rst_i}}) |
			(active & ~external_i & {NUM_SRC{st_q.primed}}) | st_q.edge_flag));
	end

	// State register.
	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end
endmodule : vic_source_detect

// ===== vic_core.sv
// Top of the vectored interrupt controller with register port and arbitration.
`timescale 1ns/1ps
// Notes on behaviour
// - No pending source returns the spurious vector.
// - Global mask forces both request lines inactive.
// - Global mask does not block idle wake-up.
// - Decode a 4 Kbyte window at fixed base.
// - Three-bit priority, zero lowest, seven highest.
// - Source zero priority ignored in arbitration.
// - Trigger sense decodes per internal or external.
// - Internal sources have fixed polarity and direction.
// - Thirty-two writable handler address registers.
// - Reset clears internal pending, external levels live.
// - Normal vector read returns current handler address.
// - Fast vector read returns source zero handler.
// - Protect mode defers stacking to a write.
module vic_core #(
	parameter logic [31:0] EXTERNAL_SRC = vic_pkg::EXTERNAL_SRC_DEFAULT
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [vic_pkg::NUM_SRC-1:0] src_i,
	output logic normal_request_n_o,
	output logic fast_request_n_o,
	output logic wake_o,
	output logic irq_o
);
	import vic_pkg::*;

	typedef struct packed {
		logic [NUM_SRC-1:0][MODE_W-1:0] mode;
		logic [NUM_SRC-1:0][31:0] handler;
		logic [31:0] spurious;
		logic [1:0] debug;
		logic [NUM_SRC-1:0] enabled;
		logic [NUM_SRC-1:0] fast_redirect;
		logic [4:0] current_id;
		logic [STACK_DEPTH-1:0][2:0] prio_stack;
		logic [STACK_DEPTH-1:0][4:0] id_stack;
		logic [3:0] depth;
		logic [4:0] memo_id;
		logic memo_valid;
		vic_state_e state;
		logic [EVT_W-1:0] evt_status;
		logic [EVT_W-1:0] evt_mask;
		logic [31:0] rdata;
		logic normal_n;
		logic fast_n;
	} vic_core_s;

	vic_core_s st_q;
	vic_core_s st_d;
	logic [NUM_SRC-1:0] pending;
	logic [NUM_SRC-1:0] edge_mode;
	logic [NUM_SRC-1:0] active_high;
	logic [NUM_SRC-1:0] set_cmd;
	logic [NUM_SRC-1:0] clear_cmd;
	logic [NUM_SRC-1:0] live;
	logic in_window;
	logic [11:0] off;
	logic normal_want;
	logic fast_want;
	logic [4:0] win_id;
	logic win_valid;
	logic [2:0] cur_level;
	logic [EVT_W-1:0] evt_set;

	////////////////////////////////////////////////////////////////////////////////
	// Word index of an offset inside an array of registers.
	function automatic logic [4:0] word_index(input logic [11:0] a, input logic [11:0] first);
		logic [11:0] rel;
		rel = a - first;
		return rel[6:2];
	endfunction : word_index

	// Priority of a source as arbitration sees it.
	function automatic logic [2:0] prio_of(input logic [MODE_W-1:0] m);
		return m[PRIO_LSB +: PRIO_W];
	endfunction : prio_of

	////////////////////////////////////////////////////////////////////////////////
	// Window address decode
	assign in_window = (addr_i & WINDOW_MASK) == BASE_ADDR;
	assign off = addr_i[11:0];

	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			edge_mode[i] = st_q.mode[i][SENSE_LSB];
			active_high[i] = EXTERNAL_SRC[i] ? st_q.mode[i][SENSE_LSB+1] : 1'b1;
		end
	end

	// Set and clear commands; reading the fast vector clears an edge source zero.
	always_comb begin
		set_cmd = '0;
		clear_cmd = '0;
		if (wr_i && in_window && off == OFF_SET_CMD) begin
			set_cmd = wdata_i;
		end
		if (wr_i && in_window && off == OFF_CLEAR_CMD) begin
			clear_cmd = wdata_i;
		end
		if (rd_i && in_window && off == OFF_FAST_VECTOR && edge_mode[0]) begin
			clear_cmd[0] = 1'b1;
		end
		if (st_d.memo_valid && !st_q.memo_valid && st_d.state == VIC_SERVE) begin
			clear_cmd[st_d.current_id] = clear_cmd[st_d.current_id] | edge_mode[st_d.current_id];
		end
	end

	vic_source_detect u_detect (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.src_i(src_i),
		.external_i(EXTERNAL_SRC),
		.edge_mode_i(edge_mode),
		.active_high_i(active_high),
		.set_i(set_cmd),
		.clear_i(clear_cmd),
		.pending_o(pending)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Priority arbitration
	always_comb begin
		live = pending & st_q.enabled & ~st_q.fast_redirect;
		win_id = '0;
		win_valid = 1'b0;
		cur_level = (st_q.depth == 4'h0) ? 3'h0 : st_q.prio_stack[st_q.depth - 4'h1];
		for (int i = 1; i < NUM_SRC; i++) begin
			if (live[i] && (!win_valid || prio_of(st_q.mode[i]) > prio_of(st_q.mode[win_id]))) begin
				win_id = 5'(i);
				win_valid = 1'b1;
			end
		end
		normal_want = win_valid && (st_q.depth == 4'h0 || prio_of(st_q.mode[win_id]) > cur_level);
		fast_want = (pending[0] & st_q.enabled[0]) |
			(|(pending & st_q.enabled & st_q.fast_redirect));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes, vector reads, stacking and the event status.
	always_comb begin
		st_d = st_q;
		evt_set = '0;
		st_d.rdata = RESET_WORD;
		st_d.normal_n = !(normal_want && !st_q.debug[DBG_GMASK_BIT]);
		st_d.fast_n = !(fast_want && !st_q.debug[DBG_GMASK_BIT]);
		if (wr_i && in_window) begin
			if (off <= OFF_MODE_LAST) begin
				st_d.mode[word_index(off, OFF_MODE_FIRST)] = wdata_i[MODE_W-1:0] & MODE_WMASK;
			end else if (off <= OFF_HANDLER_LAST) begin
				st_d.handler[word_index(off, OFF_HANDLER_FIRST)] = wdata_i;
			end else begin
				case (off)
					OFF_ENABLE_CMD: st_d.enabled = st_q.enabled | wdata_i;
					OFF_DISABLE_CMD: st_d.enabled = st_q.enabled & ~wdata_i;
					OFF_FAST_EN: st_d.fast_redirect = st_q.fast_redirect | {wdata_i[31:1], 1'b0};
					OFF_FAST_DIS: st_d.fast_redirect = st_q.fast_redirect & ~wdata_i;
					OFF_SPURIOUS: st_d.spurious = wdata_i;
					OFF_DEBUG: st_d.debug = wdata_i[1:0] & DBG_WMASK;
					OFF_IRQ_MASK: st_d.evt_mask = wdata_i[EVT_W-1:0];
					OFF_END_SERVICE: begin
						if (st_q.depth != 4'h0) begin
							st_d.depth = st_q.depth - 4'h1;
							st_d.current_id = (st_q.depth > 4'h1) ?
								st_q.id_stack[st_q.depth - 4'h2] : 5'h00;
						end
						st_d.state = VIC_IDLE;
						st_d.memo_valid = 1'b0;
					end
					OFF_NORMAL_VECTOR: begin
						if (st_q.debug[DBG_PROTECT_BIT] && st_q.memo_valid &&
							st_q.depth < 4'(STACK_DEPTH)) begin
							st_d.prio_stack[st_q.depth] = prio_of(st_q.mode[st_q.memo_id]);
							st_d.id_stack[st_q.depth] = st_q.memo_id;
							st_d.depth = st_q.depth + 4'h1;
							st_d.current_id = st_q.memo_id;
							st_d.state = VIC_SERVE;
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (rd_i && in_window) begin
			if (off <= OFF_MODE_LAST) begin
				st_d.rdata = {25'h0000000, st_q.mode[word_index(off, OFF_MODE_FIRST)]};
			end else if (off <= OFF_HANDLER_LAST) begin
				st_d.rdata = st_q.handler[word_index(off, OFF_HANDLER_FIRST)];
			end else begin
				case (off)
					OFF_NORMAL_VECTOR: begin
						if (normal_want) begin
							st_d.rdata = st_q.handler[win_id];
							st_d.memo_id = win_id;
							st_d.memo_valid = 1'b1;
							evt_set[EVT_NORMAL] = 1'b1;
							if (!st_q.debug[DBG_PROTECT_BIT] && st_q.depth < 4'(STACK_DEPTH)) begin
								st_d.prio_stack[st_q.depth] = prio_of(st_q.mode[win_id]);
								st_d.id_stack[st_q.depth] = win_id;
								st_d.depth = st_q.depth + 4'h1;
								st_d.current_id = win_id;
								st_d.state = VIC_SERVE;
							end else begin
								st_d.state = VIC_PROTECT_HOLD;
							end
						end else begin
							st_d.rdata = st_q.spurious;
							st_d.memo_valid = 1'b0;
							evt_set[EVT_SPURIOUS] = 1'b1;
						end
					end
					OFF_FAST_VECTOR: begin
						st_d.rdata = fast_want ? st_q.handler[0] : st_q.spurious;
						evt_set[EVT_FAST] = fast_want;
					end
					OFF_CURRENT_ID: st_d.rdata = {27'h0000000, st_q.current_id};
					OFF_PENDING: st_d.rdata = pending;
					OFF_ENABLED: st_d.rdata = st_q.enabled;
					OFF_CORE_LINES: st_d.rdata = {30'h00000000, !st_q.normal_n, !st_q.fast_n};
					OFF_SPURIOUS: st_d.rdata = st_q.spurious;
					OFF_DEBUG: st_d.rdata = {30'h00000000, st_q.debug};
					OFF_FAST_STATE: st_d.rdata = st_q.fast_redirect;
					OFF_IRQ_STATUS: st_d.rdata = {29'h00000000, st_q.evt_status};
					OFF_IRQ_MASK: st_d.rdata = {29'h00000000, st_q.evt_mask};
					default: st_d.rdata = RESET_WORD;
				endcase
			end
		end
		// Event status: write one to clear, a new event wins.
		if (wr_i && in_window && off == OFF_IRQ_STATUS) begin
			st_d.evt_status = (st_q.evt_status & ~wdata_i[EVT_W-1:0]) | evt_set;
		end else begin
			st_d.evt_status = st_q.evt_status | evt_set;
		end
		if (sys_rst_i) begin
			st_d = '0;
			st_d.state = VIC_IDLE;
			st_d.normal_n = 1'b1;
			st_d.fast_n = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign rdata_o = st_q.rdata;
	assign normal_request_n_o = st_q.normal_n;
	assign fast_request_n_o = st_q.fast_n;
	assign wake_o = normal_want | fast_want;
	assign irq_o = |(st_q.evt_status & st_q.evt_mask);
endmodule : vic_core

// ===== vic_src_model.sv
// Model of the peripherals and pins that drive the source inputs.
`timescale 1ns/1ps
module vic_src_model (
	input wire logic clk_i,
	input wire logic [31:0] level_i,
	output logic [31:0] src_o
);
	// Outputs follow the commanded levels; idle external pins rest high.
	assign src_o = level_i;
endmodule : vic_src_model

// ===== vic_core_monitor.sv
// Concurrent checks on the vectored controller ports.
`timescale 1ns/1ps
module vic_core_mon (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic normal_request_n_o,
	input wire logic fast_request_n_o,
	input wire logic irq_o
);
	import vic_pkg::*;
	logic gm_q;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////
	// Tracks the global mask bit as software writes it.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			gm_q <= 1'b0;
		end else if (wr_i && addr_i == {BASE_ADDR[31:12], OFF_DEBUG}) begin
			gm_q <= wdata_i[DBG_GMASK_BIT];
		end
	end
	// A write into a range of the window, then a read of the same word.
	sequence wr_at(logic [11:0] lo, logic [11:0] hi);
		wr_i && addr_i[31:12] == BASE_ADDR[31:12] && addr_i[11:0] >= lo && addr_i[11:0] <= hi;
	endsequence
	sequence rd_same;
		rd_i && addr_i == $past(addr_i);
	endsequence
	////////////////////////////////////////////////////////////////
	handler_rw_a: assert property (wr_at(OFF_HANDLER_FIRST, OFF_HANDLER_LAST) ##1 rd_same
		|=> rdata_o == $past(wdata_i, 2)) else $error("handler word read back wrong");
	mode_rw_a: assert property (wr_at(OFF_MODE_FIRST, OFF_MODE_LAST) ##1 rd_same
		|=> rdata_o == ($past(wdata_i, 2) & {25'h0, MODE_WMASK})) else $error("mode bad");
	spu_rw_a: assert property (wr_at(OFF_SPURIOUS, OFF_SPURIOUS) ##1 rd_same
		|=> rdata_o == $past(wdata_i, 2)) else $error("spurious word read back wrong");
	window_a: assert property (rd_i && addr_i[31:12] != BASE_ADDR[31:12]
		|=> rdata_o == 32'h0) else $error("read outside window returned data");
	wo_read_a: assert property (rd_i && addr_i[31:12] == BASE_ADDR[31:12]
		&& addr_i[11:0] >= OFF_ENABLE_CMD && addr_i[11:0] <= OFF_END_SERVICE
		|=> rdata_o == 32'h0) else $error("write-only word read back data");
	idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read answer");
	reset_out_a: assert property ($fell(sys_rst_i) |-> rdata_o == 32'h0 && !irq_o
		&& normal_request_n_o && fast_request_n_o) else $error("outputs not at reset value");
	gmask_both_a: assert property (gm_q && $past(gm_q) && $past(gm_q, 2)
		|-> normal_request_n_o && fast_request_n_o) else $error("request active under mask");
endmodule : vic_core_mon
bind vic_core vic_core_mon u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.normal_request_n_o(normal_request_n_o), .fast_request_n_o(fast_request_n_o), .irq_o(irq_o));

// ===== test_vic_core.sv
// Self-checking bench for the vectored controller.
`timescale 1ns/1ps
module test_vic_core;
	import vic_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [31:0] addr_i = 32'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] lvl = 32'hc0000000;
	logic [31:0] src_i;
	logic [31:0] rdata_o;
	logic normal_request_n_o;
	logic fast_request_n_o;
	logic wake_o;
	logic irq_o;
	int miscompares = 0;
	int cmp_count = 0;
	vic_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_i(src_i),
		.normal_request_n_o(normal_request_n_o), .fast_request_n_o(fast_request_n_o),
		.wake_o(wake_o), .irq_o(irq_o));
	vic_src_model src_m (.clk_i(clk_i), .level_i(lvl), .src_o(src_i));
	// Clock of 100 ns period.
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] ad(input logic [11:0] o);
		return {BASE_ADDR[31:12], o};
	endfunction : ad
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick;
		@(posedge clk_i);
		#1;
	endtask : tick
	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= ad(off);
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(n, e, rdata_o);
	endtask : rchk
	// Write followed with no gap by a read of the same word.
	task automatic wrrd(input string n, input logic [11:0] off, input logic [31:0] d,
		input logic [31:0] e);
		wr(off, d);
		addr_i <= ad(off);
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(n, e, rdata_o);
	endtask : wrrd
	task automatic wait_low;
		for (int i = 0; i < 20 && normal_request_n_o !== 1'b0; i++) tick();
		chk("normal_req", 32'h0, {31'h0, normal_request_n_o});
		if (normal_request_n_o !== 1'b0) report_and_stop();
	endtask : wait_low
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	// Reset values, window decode and live external level.
	task automatic t_reset;
		rchk("mode0", ad(OFF_MODE_FIRST), 32'h0);
		rchk("handler31", ad(OFF_HANDLER_LAST), 32'h0);
		rchk("debug", ad(OFF_DEBUG), 32'h0);
		rchk("pending", ad(OFF_PENDING), 32'h0);
		rchk("outside", 32'hffffe100, 32'h0);
		rchk("reserved", ad(12'h118), 32'h0);
		rchk("wo_read", ad(OFF_ENABLE_CMD), 32'h0);
		@(posedge clk_i);
		lvl[31] <= 1'b0;
		rchk("ext_low", ad(OFF_PENDING), 32'h80000000);
		@(posedge clk_i);
		lvl[31] <= 1'b1;
		$display("test reset done");
	endtask : t_reset
	// Spurious vector with the event interrupt raised, masked and cleared.
	task automatic t_spur;
		wr(OFF_IRQ_MASK, 32'h1);
		wrrd("spu", OFF_SPURIOUS, 32'h5a5a0004, 32'h5a5a0004);
		rchk("ivr_spu", ad(OFF_NORMAL_VECTOR), 32'h5a5a0004);
		tick();
		chk("irq_set", 32'h1, {31'h0, irq_o});
		wr(OFF_END_SERVICE, 32'h0);
		wr(OFF_IRQ_STATUS, 32'h7);
		tick();
		chk("irq_clr", 32'h0, {31'h0, irq_o});
		wr(OFF_IRQ_MASK, 32'h0);
		rchk("ivr_spu2", ad(OFF_NORMAL_VECTOR), 32'h5a5a0004);
		rchk("fvr_spu", ad(OFF_FAST_VECTOR), 32'h5a5a0004);
		tick();
		chk("irq_mask", 32'h0, {31'h0, irq_o});
		wr(OFF_IRQ_STATUS, 32'h7);
		$display("test spurious done");
	endtask : t_spur
	// Priorities, vectors and the fast source.
	task automatic t_vec;
		wrrd("mode1", 12'h004, 32'h3, 32'h3);
		wrrd("mode2", 12'h008, 32'hffffffff, 32'h67);
		wr(12'h008, 32'h7);
		wrrd("handler1", 12'h084, 32'h1110, 32'h1110);
		wrrd("handler2", 12'h088, 32'h2220, 32'h2220);
		wr(OFF_ENABLE_CMD, 32'h6);
		lvl[2:1] <= 2'b11;
		wait_low();
		rchk("ivr_hi", ad(OFF_NORMAL_VECTOR), 32'h2220);
		rchk("cur_id", ad(OFF_CURRENT_ID), 32'h2);
		lvl[2] <= 1'b0;
		wr(OFF_END_SERVICE, 32'h0);
		rchk("ivr_lo", ad(OFF_NORMAL_VECTOR), 32'h1110);
		lvl[1] <= 1'b0;
		wr(OFF_END_SERVICE, 32'h0);
		wrrd("handler0", 12'h080, 32'h0c00, 32'h0c00);
		wr(OFF_ENABLE_CMD, 32'h1);
		lvl[0] <= 1'b1;
		repeat (4) tick();
		chk("fast_req", 32'h0, {31'h0, fast_request_n_o});
		chk("src0_norm", 32'h1, {31'h0, normal_request_n_o});
		rchk("fvr", ad(OFF_FAST_VECTOR), 32'h0c00);
		lvl[0] <= 1'b0;
		wr(OFF_DISABLE_CMD, 32'h1);
		$display("test vector done");
	endtask : t_vec
	// Global mask silences both lines but not wake-up.
	task automatic t_gmask;
		lvl[1:0] <= 2'b11;
		wr(OFF_ENABLE_CMD, 32'h1);
		wait_low();
		wr(OFF_DEBUG, 32'h2);
		repeat (3) tick();
		chk("gm_norm", 32'h1, {31'h0, normal_request_n_o});
		chk("gm_fast", 32'h1, {31'h0, fast_request_n_o});
		chk("gm_wake", 32'h1, {31'h0, wake_o});
		wr(OFF_DEBUG, 32'h0);
		wait_low();
		chk("fast_back", 32'h0, {31'h0, fast_request_n_o});
		lvl[1:0] <= 2'b00;
		wr(OFF_DISABLE_CMD, 32'h1);
		$display("test mask done");
	endtask : t_gmask
	// Protect mode: a vector read only memorises, the write stacks.
	task automatic t_prot;
		wr(OFF_DEBUG, 32'h1);
		lvl[1] <= 1'b1;
		wait_low();
		rchk("prot_ivr", ad(OFF_NORMAL_VECTOR), 32'h1110);
		rchk("prot_noack", ad(OFF_CURRENT_ID), 32'h0);
		wr(OFF_NORMAL_VECTOR, 32'h0);
		rchk("prot_ack", ad(OFF_CURRENT_ID), 32'h1);
		lvl[1] <= 1'b0;
		wr(OFF_END_SERVICE, 32'h0);
		wr(OFF_DEBUG, 32'h0);
		$display("test protect done");
	endtask : t_prot
	// Edge senses stick; external sense 01 is falling edge.
	task automatic t_edge;
		wr(12'h00c, 32'h20);
		wr(12'h078, 32'h20);
		@(posedge clk_i);
		lvl[3] <= 1'b1;
		lvl[30] <= 1'b0;
		@(posedge clk_i);
		lvl[3] <= 1'b0;
		lvl[30] <= 1'b1;
		rchk("edges", ad(OFF_PENDING), 32'h40000008);
		wr(OFF_CLEAR_CMD, 32'h40000008);
		rchk("cleared", ad(OFF_PENDING), 32'h0);
		$display("test edge done");
	endtask : t_edge
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_spur();
		t_vec();
		t_gmask();
		t_prot();
		t_edge();
		report_and_stop();
	end
endmodule : test_vic_core
